//--- hdl/eeprom_cmd_map.svh
// Purpose: Offsets-free constant map for the serial memory command front end: framing, opcodes, timing.
// Assumes: System clock of 40 MHz; all times below are longest times and round down to cycles.
// Notes:   Definitions only; included by the front end, the assertions and the bench.
//
// How it works
// - Wide words: lead one, two opcode bits, eight address bits; 11 or 27 clocks.
// - Narrow words: nine address bits after lead one and opcode; 12 or 20 clocks.
// - Opcode 11 erases a word, 10 reads, 01 writes, 00 is extended.
// - Extended selector after opcode 00: 10 clear, 00 lock, 11 unlock, 01 fill.
// - Write and fill take a full data word; read returns a full data word.
// - Width select high gives 16-bit words, low gives 8-bit words.
// - Serial input is sampled on each rising serial clock edge.
// - Serial output floats except during read data or programming status.
// - Status drives low while programming and high once ready.
// - Serial output is released whenever device select falls.
// - Lead one is the first rising clock with select and input both high.
// - Nothing executes before a lead one has been seen.
// - Standby ends as soon as device select rises.
// - Only instructions with every bit clocked in are executed; short ones vanish.
// - Word erase or write finishes within 6 ms, or 2 ms on fast variant.
// - Bulk clear finishes within 6 ms, bulk fill within 15 ms.
// - A lead one followed by select low clears the status from the output.
// - Read sends one zero bit first, then data; address increments while selected.
// - Device starts program-locked; erase and write are refused until unlock.
// - Programming begins at the select falling edge after the last bit.
`ifndef EEPROM_CMD_MAP_SVH
`define EEPROM_CMD_MAP_SVH

// Instruction framing, counted in serial clock cycles including the lead one.
`define EE_HDR_BITS_WIDE    5'h0B
`define EE_HDR_BITS_NARROW  5'h0C
`define EE_DATA_BITS_WIDE   5'h10
`define EE_DATA_BITS_NARROW 5'h08
`define EE_OPCODE_END       5'h03

// Primary opcodes.
`define EE_OP_ERASE 2'h3
`define EE_OP_READ  2'h2
`define EE_OP_WRITE 2'h1
`define EE_OP_EXT   2'h0

// Extended selectors.
`define EE_EXT_CLEAR  2'h2
`define EE_EXT_LOCK   2'h0
`define EE_EXT_UNLOCK 2'h3
`define EE_EXT_FILL   2'h1

// Array geometry and reset values.
`define EE_ARRAY_BYTES  10'h200
`define EE_ERASED_BYTE  8'hFF
`define EE_UNLOCK_RESET 1'b0

// Timing, in nanoseconds, and the system clock period.
`define EE_CLK_PERIOD_NS       25
`define EE_WORD_TIME_SLOW_NS   6000000
`define EE_WORD_TIME_FAST_NS   2000000
`define EE_BULK_CLEAR_TIME_NS  6000000
`define EE_BULK_FILL_TIME_NS   15000000

`endif

//--- hdl/eeprom_cmd_pkg.sv
// Purpose: Types shared by the serial memory command front end.
// Assumes: Nothing beyond the constant map.
// Notes:   One-hot codes are written out.
`default_nettype none
package eeprom_cmd_pkg;

  // Decoded instruction handed from the link side to the programming side.
  typedef enum logic [5:0] {
    CMD_ERASE      = 6'b000001,
    CMD_WRITE      = 6'b000010,
    CMD_BULK_CLEAR = 6'b000100,
    CMD_BULK_FILL  = 6'b001000,
    CMD_LOCK       = 6'b010000,
    CMD_UNLOCK     = 6'b100000
  } cmd_e;

  // Programming sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_BUSY = 3'b100
  } prog_state_e;

endpackage : eeprom_cmd_pkg
`default_nettype wire

//--- hdl/bit_sync.sv
// Purpose: Two-flop synchroniser for one level.
// Assumes: The input is a level that stays put for at least two destination edges.
// Notes:   The first flop feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out.
  input  wire logic d,
  output logic      q
);

  logic meta;

  // Two stages give metastability time to settle before anything reads q.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : bit_sync
`default_nettype wire

//--- hdl/serial_eeprom_command_interface.sv
// Purpose: Three-wire command front end of a 4 Kbit serial memory with self-timed programming.
// Assumes: Serial clock comes from the host and stops between frames; select low is at least 250 ns.
// Notes:   Link logic runs on the serial clock; the programming sequencer runs on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_cmd_map.svh"
module serial_eeprom_command_interface #(
  parameter int unsigned WORD_PROG_CYCLES  = `EE_WORD_TIME_SLOW_NS / `EE_CLK_PERIOD_NS,
  parameter int unsigned WORD_FAST_CYCLES  = `EE_WORD_TIME_FAST_NS / `EE_CLK_PERIOD_NS,
  parameter bit          FAST_VARIANT      = 1'b0,
  parameter int unsigned BULK_CLEAR_CYCLES = `EE_BULK_CLEAR_TIME_NS / `EE_CLK_PERIOD_NS,
  parameter int unsigned BULK_FILL_CYCLES  = `EE_BULK_FILL_TIME_NS / `EE_CLK_PERIOD_NS
) (
  // System clock and reset.
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Serial link from the host.
  input  wire logic serialClk,
  input  wire logic serialSelect,
  input  wire logic serialIn,
  input  wire logic wordWidthSelect,
  // Serial output pin as value and enable.
  output logic      serialOut,
  output logic      serialOutEn,
  // Status levels.
  output logic      progBusy,
  output logic      progUnlocked
);

  // Array storage, one byte per entry; a wide word uses two neighbouring bytes, high byte first.
  logic [7:0] mem [0:511];

  // Link side, clocked by the serial clock.

  logic                   frameRst;
  logic                   wideL;
  logic                   leadOneSeen_r;
  logic                   frameDone_r;
  logic [4:0]             bitCnt_r;
  logic [1:0]             op_r;
  logic [8:0]             addr_r;
  logic [15:0]            data_r;
  logic [4:0]             hdrLen;
  logic [4:0]             dataLen;
  logic [1:0]             extSel;
  logic                   isRead;
  logic                   carriesData;
  logic                   hdrEdge;
  logic                   dataEdge;
  logic                   issueCmd;
  logic [8:0]             fullAddr;
  logic [8:0]             cmdAddrNow;
  eeprom_cmd_pkg::cmd_e   cmdKindNow;
  logic                   rdOn_r;
  logic [4:0]             rdCnt_r;
  logic [15:0]            rdShift_r;
  logic [8:0]             rdAddr_r;
  logic [8:0]             rdNextAddr;
  logic                   doBit_r;
  logic                   doEn_r;
  eeprom_cmd_pkg::cmd_e   cmdKind_r;
  logic [8:0]             cmdAddr_r;
  logic [15:0]            cmdData_r;
  logic                   cmdWide_r;
  logic                   cmdTog_r;
  logic                   leadTog_r;

  // Select low ends the frame at once, even with the serial clock stopped.
  assign frameRst = sys_rst | ~serialSelect;

  // Width select is static, so a plain two-flop capture on the link clock is enough.
  bit_sync u_widthSync (
    .clk (serialClk),
    .rst (sys_rst),
    .d   (wordWidthSelect),
    .q   (wideL)
  );

  // Frame lengths follow the word width.
  assign hdrLen  = wideL ? `EE_HDR_BITS_WIDE : `EE_HDR_BITS_NARROW;
  assign dataLen = wideL ? `EE_DATA_BITS_WIDE : `EE_DATA_BITS_NARROW;

  // The extended selector is the first two address bits; before the header is complete one bit is still missing.
  always_comb begin
    if (bitCnt_r < hdrLen) begin
      extSel = wideL ? addr_r[6:5] : addr_r[7:6];
    end else begin
      extSel = wideL ? addr_r[7:6] : addr_r[8:7];
    end
  end

  // Instruction classification and the edges that complete a frame.
  assign isRead      = (op_r == `EE_OP_READ);
  assign carriesData = (op_r == `EE_OP_WRITE) || ((op_r == `EE_OP_EXT) && (extSel == `EE_EXT_FILL));
  assign hdrEdge     = leadOneSeen_r && !frameDone_r && (bitCnt_r == hdrLen - 5'h01);
  assign dataEdge    = leadOneSeen_r && !frameDone_r && (bitCnt_r == hdrLen + dataLen - 5'h01);
  assign issueCmd    = (hdrEdge && !carriesData && !isRead) || (dataEdge && carriesData);
  assign fullAddr    = wideL ? {1'b0, addr_r[6:0], serialIn} : {addr_r[7:0], serialIn};
  assign cmdAddrNow  = (bitCnt_r < hdrLen) ? fullAddr : addr_r;

  // Opcode decode for everything that is handed over; reads stay on the link side.
  always_comb begin
    cmdKindNow = eeprom_cmd_pkg::CMD_LOCK;
    case (op_r)
      `EE_OP_ERASE: cmdKindNow = eeprom_cmd_pkg::CMD_ERASE;
      `EE_OP_WRITE: cmdKindNow = eeprom_cmd_pkg::CMD_WRITE;
      `EE_OP_EXT: begin
        case (extSel)
          `EE_EXT_CLEAR:  cmdKindNow = eeprom_cmd_pkg::CMD_BULK_CLEAR;
          `EE_EXT_UNLOCK: cmdKindNow = eeprom_cmd_pkg::CMD_UNLOCK;
          `EE_EXT_FILL:   cmdKindNow = eeprom_cmd_pkg::CMD_BULK_FILL;
          default:        cmdKindNow = eeprom_cmd_pkg::CMD_LOCK;
        endcase
      end
      default: cmdKindNow = eeprom_cmd_pkg::CMD_LOCK;
    endcase
  end

  // Frame receiver: waits for the lead one, then shifts opcode, address and data MSB first.
  // Bits beyond a complete frame are ignored until select drops.
  always_ff @(posedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      leadOneSeen_r <= 1'b0;
      frameDone_r   <= 1'b0;
      bitCnt_r      <= 5'h00;
      op_r          <= 2'h0;
      addr_r        <= 9'h000;
      data_r        <= 16'h0000;
    end else if (!leadOneSeen_r) begin
      if (serialIn) begin
        leadOneSeen_r <= 1'b1;
        bitCnt_r      <= 5'h01;
      end
    end else if (!frameDone_r) begin
      bitCnt_r <= bitCnt_r + 5'h01;
      if (bitCnt_r < `EE_OPCODE_END) begin
        op_r <= {op_r[0], serialIn};
      end else if (bitCnt_r < hdrLen) begin
        addr_r <= {addr_r[7:0], serialIn};
      end else begin
        data_r <= {data_r[14:0], serialIn};
      end
      if (issueCmd || (hdrEdge && isRead)) begin
        frameDone_r <= 1'b1;
      end
    end
  end

  // One aligned read word, always left-justified so bit 15 is the next to leave.
  function automatic logic [15:0] word_at(input logic [8:0] a, input logic w);
    logic [15:0] v;
    v = w ? {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]} : {mem[a], 8'h00};
    return v;
  endfunction : word_at

  // Sequential reads wrap within the array of the current width.
  assign rdNextAddr = wideL ? {1'b0, rdAddr_r[7:0] + 8'h01} : rdAddr_r + 9'h001;

  // Read shifter: the dummy zero goes out with the last address bit, data on later rising edges.
  // The array is read across domains; it is quiet unless the host reads while programming, which it must not.
  always_ff @(posedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      rdOn_r    <= 1'b0;
      rdCnt_r   <= 5'h00;
      rdShift_r <= 16'h0000;
      rdAddr_r  <= 9'h000;
      doBit_r   <= 1'b0;
      doEn_r    <= 1'b0;
    end else if (hdrEdge && isRead) begin
      rdOn_r    <= 1'b1;
      doEn_r    <= 1'b1;
      doBit_r   <= 1'b0;
      rdAddr_r  <= fullAddr;
      rdShift_r <= word_at(fullAddr, wideL);
      rdCnt_r   <= dataLen;
    end else if (rdOn_r) begin
      doBit_r <= rdShift_r[15];
      if (rdCnt_r == 5'h01) begin
        rdAddr_r  <= rdNextAddr;
        rdShift_r <= word_at(rdNextAddr, wideL);
        rdCnt_r   <= dataLen;
      end else begin
        rdShift_r <= {rdShift_r[14:0], 1'b0};
        rdCnt_r   <= rdCnt_r - 5'h01;
      end
    end
  end

  // Hand-over registers survive select low; one toggle announces a complete instruction, the other a lead one.
  // A lead one lives only until select falls, too short to sync; a lead one and a complete frame never share an edge.
  always_ff @(posedge serialClk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdKind_r <= eeprom_cmd_pkg::CMD_LOCK;
      cmdAddr_r <= 9'h000;
      cmdData_r <= 16'h0000;
      cmdWide_r <= 1'b0;
      cmdTog_r  <= 1'b0;
      leadTog_r <= 1'b0;
    end else if (issueCmd) begin
      cmdKind_r <= cmdKindNow;
      cmdAddr_r <= cmdAddrNow;
      cmdData_r <= {data_r[14:0], serialIn};
      cmdWide_r <= wideL;
      cmdTog_r  <= ~cmdTog_r;
    end else if (serialSelect && !leadOneSeen_r && serialIn) begin
      leadTog_r <= ~leadTog_r;
    end
  end

  // Programming side, clocked by clk_sys.

  eeprom_cmd_pkg::prog_state_e state_r;
  eeprom_cmd_pkg::cmd_e        exKind_r;
  logic                        selS;
  logic                        leadS;
  logic                        togS;
  logic                        togPrev_r;
  logic                        leadPrev_r;
  logic                        newCmd;
  logic [8:0]                  exAddr_r;
  logic [15:0]                 exData_r;
  logic                        exWide_r;
  logic                        unlocked_r;
  logic [23:0]                 progCnt_r;
  logic [23:0]                 progLoad;
  logic [9:0]                  idx_r;
  logic [9:0]                  writeLen;
  logic                        isBulk;
  logic                        memWe;
  logic [8:0]                  memWa;
  logic [7:0]                  memWd;
  logic [7:0]                  dataByte;
  logic                        armed_r;
  logic                        statusEn_r;
  logic                        statusBit_r;

  // Select, lead-one toggle and hand-over toggle are levels from other domains.
  bit_sync u_selSync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (serialSelect),
    .q   (selS)
  );
  bit_sync u_leadSync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (leadTog_r),
    .q   (leadS)
  );
  bit_sync u_togSync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (cmdTog_r),
    .q   (togS)
  );

  // Edges of the synchronised toggles mark a new instruction or a lead one.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      togPrev_r  <= 1'b0;
      leadPrev_r <= 1'b0;
    end else begin
      togPrev_r  <= togS;
      leadPrev_r <= leadS;
    end
  end
  assign newCmd = togS ^ togPrev_r;

  // Cycle budget per operation; counts are longest times rounded down.
  always_comb begin
    case (exKind_r)
      eeprom_cmd_pkg::CMD_BULK_CLEAR: progLoad = BULK_CLEAR_CYCLES[23:0];
      eeprom_cmd_pkg::CMD_BULK_FILL:  progLoad = BULK_FILL_CYCLES[23:0];
      default: progLoad = FAST_VARIANT ? WORD_FAST_CYCLES[23:0] : WORD_PROG_CYCLES[23:0];
    endcase
  end

  // Bulk operations sweep all bytes; a single word is one or two bytes.
  assign isBulk   = (exKind_r == eeprom_cmd_pkg::CMD_BULK_CLEAR) || (exKind_r == eeprom_cmd_pkg::CMD_BULK_FILL);
  assign writeLen = isBulk ? `EE_ARRAY_BYTES : (exWide_r ? 10'h002 : 10'h001);
  assign dataByte = (exWide_r && !idx_r[0]) ? exData_r[15:8] : exData_r[7:0];
  assign memWe    = (state_r == eeprom_cmd_pkg::ST_BUSY) && (idx_r < writeLen);
  assign memWa    = isBulk ? idx_r[8:0] : (exWide_r ? {exAddr_r[7:0], idx_r[0]} : exAddr_r);
  assign memWd    = ((exKind_r == eeprom_cmd_pkg::CMD_ERASE) || (exKind_r == eeprom_cmd_pkg::CMD_BULK_CLEAR))
                    ? `EE_ERASED_BYTE : dataByte;

  // Sequencer: accept, wait for select low, then run the self-timed cycle.
  // Instructions that complete while busy are dropped; the host is expected to poll first.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= eeprom_cmd_pkg::ST_IDLE;
      unlocked_r <= `EE_UNLOCK_RESET;
      exKind_r   <= eeprom_cmd_pkg::CMD_LOCK;
      exAddr_r   <= 9'h000;
      exData_r   <= 16'h0000;
      exWide_r   <= 1'b0;
      progCnt_r  <= 24'h000000;
      idx_r      <= 10'h000;
    end else begin
      case (state_r)
        eeprom_cmd_pkg::ST_IDLE: begin
          if (newCmd) begin
            exKind_r <= cmdKind_r;
            exAddr_r <= cmdAddr_r;
            exData_r <= cmdData_r;
            exWide_r <= cmdWide_r;
            if (cmdKind_r == eeprom_cmd_pkg::CMD_LOCK) begin
              unlocked_r <= 1'b0;
            end else if (cmdKind_r == eeprom_cmd_pkg::CMD_UNLOCK) begin
              unlocked_r <= 1'b1;
            end else if (unlocked_r) begin
              state_r <= eeprom_cmd_pkg::ST_WAIT;
            end
          end
        end
        eeprom_cmd_pkg::ST_WAIT: begin
          if (!selS) begin
            state_r   <= eeprom_cmd_pkg::ST_BUSY;
            progCnt_r <= progLoad;
            idx_r     <= 10'h000;
          end
        end
        eeprom_cmd_pkg::ST_BUSY: begin
          if (idx_r < writeLen) begin
            idx_r <= idx_r + 10'h001;
          end
          if (progCnt_r > 24'h000001) begin
            progCnt_r <= progCnt_r - 24'h000001;
          end else if (!memWe) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE;
          end
        end
        default: state_r <= eeprom_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Array writes; stored data has no reset, as a nonvolatile array would not.
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // Status presentation: armed by a programming start, removed by a later lead one.
  // Arming wins over clearing when both happen in one cycle.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      armed_r     <= 1'b0;
      statusEn_r  <= 1'b0;
      statusBit_r <= 1'b1;
    end else begin
      if ((state_r == eeprom_cmd_pkg::ST_WAIT) && !selS) begin
        armed_r <= 1'b1;
      end else if (leadS ^ leadPrev_r) begin
        armed_r <= 1'b0;
      end
      statusEn_r  <= armed_r && selS && !(leadS ^ leadPrev_r);
      statusBit_r <= (state_r != eeprom_cmd_pkg::ST_BUSY);
    end
  end

  // Pin drive: read data has priority; both sources are registered in their own domain.
  assign serialOut    = doEn_r ? doBit_r : statusBit_r;
  assign serialOutEn  = doEn_r | statusEn_r;
  assign progBusy     = state_r[2];
  assign progUnlocked = unlocked_r;

endmodule : serial_eeprom_command_interface
`default_nettype wire

//--- verification/serial_eeprom_command_interface_asserts.sv
// Purpose: Pin-level checks of the serial memory front end.
// Assumes: No reads while programming; bulk fill is the longest cycle.
// Notes:   Bound to the design below the module.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_cmd_map.svh"
module serial_eeprom_command_interface_asserts #(
  parameter int unsigned BULK_FILL_CYCLES = 600000
) (
  // Clocks and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serialClk,
  // Link inputs.
  input wire logic serialSelect,
  input wire logic serialIn,
  input wire logic wordWidthSelect,
  // Outputs.
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic progBusy,
  input wire logic progUnlocked
);
  int unsigned busyCnt;
  logic        frameOn;
  logic [4:0]  edgeCnt;
  logic [1:0]  opSeen;

  // Cycles spent busy; a stuck sequencer grows it without limit.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) busyCnt <= 0;
    else busyCnt <= progBusy ? busyCnt + 1 : 0;
  end

  // Edges since the lead one; it saturates so a long read never looks like a header.
  always_ff @(posedge serialClk or negedge serialSelect or posedge sys_rst) begin
    if (sys_rst || !serialSelect) begin
      frameOn <= 1'b0;
      edgeCnt <= 5'h00;
      opSeen  <= 2'h0;
    end else if (frameOn || serialIn) begin
      frameOn <= 1'b1;
      edgeCnt <= (edgeCnt == 5'h1F) ? edgeCnt : edgeCnt + 5'h01;
      if (edgeCnt == 5'h01 || edgeCnt == 5'h02) opSeen <= {opSeen[0], serialIn};
    end
  end

  sequence s_readHeader;
    frameOn && opSeen == `EE_OP_READ && edgeCnt == (wordWidthSelect ? `EE_HDR_BITS_WIDE : `EE_HDR_BITS_NARROW);
  endsequence
  sequence s_released;
    !serialOutEn ##1 (!serialOutEn)[*4];
  endsequence
  property p_readDummy;
    @(posedge serialClk) disable iff (sys_rst || !serialSelect) s_readHeader |-> serialOutEn && !serialOut;
  endproperty
  property p_release;
    @(posedge clk_sys) disable iff (sys_rst) $fell(serialSelect) |-> ##[0:4] s_released;
  endproperty
  property p_pollStatus;
    @(posedge clk_sys) disable iff (sys_rst) $rose(serialSelect) && progBusy |-> ##4 serialOutEn && !serialOut;
  endproperty
  property p_ready;
    @(posedge clk_sys) disable iff (sys_rst) $fell(progBusy) && serialSelect |-> ##[0:2] serialOutEn && serialOut;
  endproperty
  property p_startAfterDeselect;
    @(posedge clk_sys) disable iff (sys_rst) $rose(progBusy) |-> !serialSelect && !$past(serialSelect);
  endproperty
  property p_lockedIdle;
    @(posedge clk_sys) disable iff (sys_rst) $rose(progBusy) |-> progUnlocked;
  endproperty
  property p_busyBound;
    @(posedge clk_sys) disable iff (sys_rst) progBusy |-> busyCnt <= BULK_FILL_CYCLES + 8;
  endproperty
  property p_resetState;
    @(posedge clk_sys) disable iff (sys_rst) $fell(sys_rst) |-> !progBusy && !progUnlocked && !serialOutEn;
  endproperty

  a_readDummy: assert property (p_readDummy)
    else $error("read lacks dummy zero");
  a_release: assert property (p_release)
    else $error("output kept after deselect");
  a_pollStatus: assert property (p_pollStatus)
    else $error("busy status not shown");
  a_ready: assert property (p_ready)
    else $error("ready status not shown");
  a_startAfterDeselect: assert property (p_startAfterDeselect)
    else $error("programming began while selected");
  a_lockedIdle: assert property (p_lockedIdle)
    else $error("programming while locked");
  a_busyBound: assert property (p_busyBound)
    else $error("programming too long");
  a_resetState: assert property (p_resetState)
    else $error("wrong state after reset");
endmodule : serial_eeprom_command_interface_asserts

bind serial_eeprom_command_interface serial_eeprom_command_interface_asserts #(
  .BULK_FILL_CYCLES(BULK_FILL_CYCLES)
) assertsInst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .serialClk(serialClk), .serialSelect(serialSelect),
  .serialIn(serialIn), .wordWidthSelect(wordWidthSelect), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .progBusy(progBusy), .progUnlocked(progUnlocked)
);
`default_nettype wire

//--- verification/serial_host_model.sv
// Purpose: Host that clocks frames into the memory and gathers its answer.
// Assumes: Link clock of 6 ns that stands still between frames.
// Notes:   Select stays low 300 ns after every frame.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // Link towards the device.
  output logic      serialClk,
  output logic      serialSelect,
  output logic      serialIn,
  // Device answer.
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic [63:0] rxBits;

  // Idle link before the first frame.
  initial begin
    serialClk    = 1'b0;
    serialSelect = 1'b0;
    serialIn     = 1'b0;
    rxBits       = 64'h0;
  end

  // Select rises with the clock low, so no lead one is faked.
  task automatic raiseSelect();
    serialSelect = 1'b1;
  endtask : raiseSelect

  // Sends n bits, MSB first; a released pin reads as the inverse of its last level.
  task automatic frame(input logic [63:0] bits, input int n);
    raiseSelect();
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #1.5 serialClk = 1'b1;
      #3 serialClk = 1'b0;
      rxBits = {rxBits[62:0], serialOutEn ? serialOut : ~rxBits[0]};
      #1.5;
    end
    serialSelect = 1'b0;
    serialIn = ~serialIn;
    #300;
  endtask : frame
endmodule : serial_host_model
`default_nettype wire

//--- verification/serial_eeprom_command_interface_test.sv
// Purpose: Self-checking bench for the serial memory front end.
// Assumes: Shortened self-timed counts; array contents unknown until written.
// Notes:   The host model owns the link pins; this module drives width and reset.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_cmd_map.svh"
module serial_eeprom_command_interface_test;
  localparam int WORD_CYC    = 600;
  localparam int CLEAR_CYC   = 600;
  localparam int FILL_CYC    = 700;
  localparam int TIMEOUT_CYC = 20000;

  logic clk_sys;
  logic sys_rst;
  logic wordWidthSelect;
  wire  serialClk, serialSelect, serialIn, serialOut, serialOutEn, progBusy, progUnlocked;
  int   miscompares = 0;
  int   comparisons = 0;
  int   cycleCount  = 0;

  serial_eeprom_command_interface #(
    .WORD_PROG_CYCLES (WORD_CYC),
    .BULK_CLEAR_CYCLES(CLEAR_CYC),
    .BULK_FILL_CYCLES (FILL_CYC)
  ) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serialClk(serialClk), .serialSelect(serialSelect),
    .serialIn(serialIn), .wordWidthSelect(wordWidthSelect), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .progBusy(progBusy), .progUnlocked(progUnlocked)
  );

  serial_host_model host (
    .serialClk(serialClk), .serialSelect(serialSelect), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  // System clock, 25 ns.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // A hang ends the run as a failure.
  always @(posedge clk_sys) begin
    cycleCount++;
    if (cycleCount == TIMEOUT_CYC) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  // Extended selector sits in the two leading address bits.
  function automatic logic [8:0] ext(input logic [1:0] sel);
    return wordWidthSelect ? {1'b0, sel, 6'h00} : {sel, 7'h00};
  endfunction : ext

  // Header, then nData data cycles, after lead idle-zero cycles.
  task automatic cmd(input logic [1:0] op, input logic [8:0] addr, input logic [15:0] data,
                     input int nData, input int lead);
    logic [63:0] bits;
    bits = wordWidthSelect ? {53'h0, 1'b1, op, addr[7:0]} : {52'h0, 1'b1, op, addr};
    bits = (bits << nData) | {48'h0, data};
    host.frame(bits, (wordWidthSelect ? 11 : 12) + nData + lead);
  endtask : cmd

  task automatic readCheck(input logic [8:0] addr, input logic [31:0] exp, input int nData, input int lead);
    cmd(`EE_OP_READ, addr, 16'h0000, nData, lead);
    check(host.rxBits & ((64'h1 << (nData + 1)) - 64'h1), {32'h0, exp});
    check(serialOutEn, 1'b0);
  endtask : readCheck

  // Programming: busy poll, ready, then lead one and deselect to clear the status.
  task automatic progOp(input logic [1:0] op, input logic [8:0] addr, input logic [15:0] data,
                        input int nData, input int maxCyc);
    int waited;
    cmd(op, addr, data, nData, 0);
    check(progBusy, 1'b1);
    host.raiseSelect();
    repeat (6) @(negedge clk_sys);
    check({serialOutEn, serialOut}, 2'b10);
    waited = 0;
    while (progBusy !== 1'b0 && waited <= maxCyc) begin
      @(negedge clk_sys);
      waited++;
    end
    check(waited < maxCyc, 1'b1);
    repeat (3) @(negedge clk_sys);
    check({serialOutEn, serialOut}, 2'b11);
    host.frame(64'h1, 1);
    check(serialOutEn, 1'b0);
    host.raiseSelect();
    repeat (6) @(negedge clk_sys);
    check(serialOutEn, 1'b0);
    host.frame(64'h0, 0);
  endtask : progOp

  // Main sequence: wide words first, then narrow.
  initial begin
    sys_rst = 1'b1;
    wordWidthSelect = 1'b1;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    check({progBusy, progUnlocked, serialOutEn}, 3'b000);
    cmd(`EE_OP_WRITE, 9'h005, 16'hA5C3, 16, 3);
    check(progBusy, 1'b0);
    cmd(`EE_OP_EXT, ext(2'h3), 16'h0000, 0, 3);
    check(progUnlocked, 1'b1);
    progOp(`EE_OP_WRITE, 9'h005, 16'hA5C3, 16, WORD_CYC);
    readCheck(9'h005, 32'h0000A5C3, 16, 0);
    progOp(`EE_OP_ERASE, 9'h005, 16'h0000, 0, WORD_CYC);
    readCheck(9'h005, 32'h0000FFFF, 16, 0);
    cmd(`EE_OP_WRITE, 9'h006, 16'h0000, 15, 0);
    check(progBusy, 1'b0);
    progOp(`EE_OP_EXT, ext(2'h1), 16'h3C5A, 16, FILL_CYC);
    progOp(`EE_OP_WRITE, 9'h000, 16'h1234, 16, WORD_CYC);
    readCheck(9'h0FF, 32'h3C5A1234, 32, 0);
    wordWidthSelect = 1'b0;
    readCheck(9'h1FF, 32'h0000005A, 8, 3);
    readCheck(9'h000, 32'h00000012, 8, 0);
    progOp(`EE_OP_EXT, ext(2'h2), 16'h0000, 0, CLEAR_CYC);
    readCheck(9'h000, 32'h000000FF, 8, 0);
    cmd(`EE_OP_EXT, ext(2'h0), 16'h0000, 0, 0);
    check(progUnlocked, 1'b0);
    cmd(`EE_OP_WRITE, 9'h000, 16'h0033, 8, 0);
    check(progBusy, 1'b0);
    readCheck(9'h000, 32'h000000FF, 8, 0);
    wrap_up();
  end
endmodule : serial_eeprom_command_interface_test
`default_nettype wire
